// >>> inc/pcsc_consts.svh
`ifndef PCSC_CONSTS_SVH
`define PCSC_CONSTS_SVH

// Transfer lengths that pick the target register
`define PCSC_LEN_CFG 5'h08
`define PCSC_LEN_R 5'h10
`define PCSC_LEN_A 5'h18
`define PCSC_LEN_INIT 5'h05
`define PCSC_INIT_GROUPS 2'h3

// Configuration register field positions
`define PCSC_C_POL 7
`define PCSC_C_DSEL 6
`define PCSC_C_LDE 5
`define PCSC_C_HOLD 4
`define PCSC_C_STEP_HI 3
`define PCSC_C_STEP_LO 2
`define PCSC_C_PORT 1
`define PCSC_C_OUTB 0
`define PCSC_CFG_RESET 8'h00

// R register layout
`define PCSC_R_MODE_HI 15
`define PCSC_R_MODE_LO 13
`define PCSC_R_DIV_HI 12
`define PCSC_R_MODE_RESET 3'h6
`define PCSC_R_DIV_RESET 13'h0001
`define PCSC_REF_LOW 3'h0
`define PCSC_REF_PASS 3'h3
`define PCSC_REF_DIV2 3'h4

// A register layout
`define PCSC_A_FUNC_HI 23
`define PCSC_A_FUNC_LO 22
`define PCSC_A_TOTAL_HI 17
`define PCSC_A_RESET 24'h000000
`define PCSC_A_PORT_CODE 2'h1

// Init hold time and its cycle count at the core clock
`define PCSC_INIT_HOLD_NS 100
`define PCSC_CLK_PERIOD_NS 8
`define PCSC_INIT_HOLD_CYC ((`PCSC_INIT_HOLD_NS + `PCSC_CLK_PERIOD_NS - 1) / `PCSC_CLK_PERIOD_NS)

`endif

// >>> inc/pcsc_pkg.sv
package pcsc_pkg;

  // One finished serial transfer
  typedef struct packed {
    logic [4:0] count;
    logic [23:0] data;
  } pcsc_frame_t;

  // Configuration register fields
  typedef struct packed {
    logic detector_polarity;
    logic detector_select;
    logic lock_detect_enable;
    logic low_power_hold;
    logic current_step_high;
    logic current_step_low;
    logic port_bit;
    logic outb_bit;
  } pcsc_cfg_t;

  typedef enum logic [1:0] {PCSC_RUN, PCSC_HOLD, PCSC_ARM} pcsc_state_t;

endpackage

// >>> test/pcsc_host.sv
`timescale 1ns/1ps
// Host side of the three-wire port; serial clock idles low
module pcsc_host (
  input wire logic clk,
  output logic sck,
  output logic sdi,
  output logic strobe_n
);
  // Idle pins at time zero
  initial begin
    sck = 1'b0;
    sdi = 1'b0;
    strobe_n = 1'b1;
  end

  // One frame MSB first, 80 ns clock; init frames end with clock high
  task automatic send(input logic [4:0] len, input logic [23:0] data, input logic init);
    @(posedge clk);
    strobe_n <= 1'b0;
    for (int i = int'(len) - 1; i >= 0; i--) begin
      sdi <= data[i];
      repeat (5) @(posedge clk);
      sck <= 1'b1;
      repeat (5) @(posedge clk);
      if (i > 0 || !init) sck <= 1'b0;
    end
    repeat (5) @(posedge clk);
    strobe_n <= 1'b1;
    sdi <= ~sdi;
    repeat (16) @(posedge clk);
    sck <= 1'b0;
    repeat (12) @(posedge clk);
  endtask
endmodule

// >>> test/pcsc_top_monitor.sv
`timescale 1ns/1ps
// Port-level checks on the synthesizer control block
module pcsc_top_monitor #(
  parameter int R_WIDTH = 13,
  parameter int FB_WIDTH = 18
) (
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic SER_CLK,
  input wire logic SER_DATA,
  input wire logic SERIAL_LATCH_STROBE_N,
  input wire logic REFERENCE_INPUT,
  input wire logic VCO_INPUT,
  input wire logic REFERENCE_OUTPUT,
  input wire logic CHARGE_PUMP_OUTPUT,
  input wire logic CHARGE_PUMP_OE,
  input wire logic [6:0] CP_CURRENT_PCT,
  input wire logic REF_PULSE_OUT_N,
  input wire logic FB_PULSE_OUT_N,
  input wire logic LOCK_DETECT_OUTPUT,
  input wire logic OUTPUT_A,
  input wire logic OUTPUT_B_O,
  input wire logic OUTPUT_B_OE,
  input wire logic BIAS_CURRENT_ON,
  input wire logic REF_RESISTOR_ON
);
  logic strobe_q;
  logic [7:0] since_rise;

  default clocking @(posedge CLK); endclocking
  default disable iff (!RST_N);

  // Cycles since the latch strobe last rose, saturating
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      strobe_q <= 1'b1;
      since_rise <= 8'hFF;
    end else begin
      strobe_q <= SERIAL_LATCH_STROBE_N;
      if (SERIAL_LATCH_STROBE_N && !strobe_q) since_rise <= 8'h00;
      else if (since_rise != 8'hFF) since_rise <= since_rise + 8'h01;
    end
  end

  reset_values_a: assert property (
    $rose(RST_N) |-> CP_CURRENT_PCT == 7'h46 && OUTPUT_B_OE && !LOCK_DETECT_OUTPUT && !CHARGE_PUMP_OE
      && REF_PULSE_OUT_N && FB_PULSE_OUT_N) else $error("bad values after reset");
  hold_forces_a: assert property (
    !BIAS_CURRENT_ON |-> !CHARGE_PUMP_OE && REF_PULSE_OUT_N && FB_PULSE_OUT_N)
    else $error("hold does not force outputs");
  pump_excl_a: assert property (
    CHARGE_PUMP_OE |-> REF_PULSE_OUT_N && FB_PULSE_OUT_N) else $error("pump and pair both active");
  lock_and_a: assert property (
    BIAS_CURRENT_ON && (!REF_PULSE_OUT_N || !FB_PULSE_OUT_N) |-> ##[0:1] (!LOCK_DETECT_OUTPUT || !BIAS_CURRENT_ON))
    else $error("lock high while a pulse is low");
  od_low_a: assert property (
    !OUTPUT_B_O) else $error("open drain drives high");
  cfg_at_frame_a: assert property (
    $changed(CP_CURRENT_PCT) || $changed(OUTPUT_B_OE) || $changed(BIAS_CURRENT_ON) |-> since_rise <= 8'h18)
    else $error("setting moved without a frame");
  pct_legal_a: assert property (
    CP_CURRENT_PCT inside {7'h19, 7'h32, 7'h46, 7'h4B, 7'h50, 7'h5A, 7'h64}) else $error("illegal current step");
  res_hold_a: assert property (
    !REF_RESISTOR_ON |-> !BIAS_CURRENT_ON) else $error("resistor off outside hold");
  recover_a: assert property (
    $rose(BIAS_CURRENT_ON) |-> REF_RESISTOR_ON && REF_PULSE_OUT_N && FB_PULSE_OUT_N)
    else $error("pulses not blocked on recovery");
  hold_lock_a: assert property (
    !BIAS_CURRENT_ON && !$past(BIAS_CURRENT_ON) |-> $stable(LOCK_DETECT_OUTPUT) || since_rise <= 8'h18)
    else $error("lock moves in hold");
endmodule

bind pcsc_top pcsc_top_monitor #(.R_WIDTH(R_WIDTH), .FB_WIDTH(FB_WIDTH)) mon_u (.*);

// >>> test/pcsc_top_tb.sv
`timescale 1ns/1ps
// Bench: host model loads registers, watcher compares snapshots
module pcsc_top_tb;
  logic CLK = 1'b0;
  logic RST_N = 1'b0;
  logic REFERENCE_INPUT = 1'b0;
  logic VCO_INPUT = 1'b0;
  logic SER_CLK, SER_DATA, SERIAL_LATCH_STROBE_N;
  logic REFERENCE_OUTPUT, CHARGE_PUMP_OUTPUT, CHARGE_PUMP_OE, REF_PULSE_OUT_N, FB_PULSE_OUT_N;
  logic LOCK_DETECT_OUTPUT, OUTPUT_A, OUTPUT_B_O, OUTPUT_B_OE, BIAS_CURRENT_ON, REF_RESISTOR_ON;
  logic [6:0] CP_CURRENT_PCT;
  logic [35:0] notes[$];
  logic [35:0] nt;
  logic sample = 1'b0;
  logic [7:0] c;
  logic [7:0] pm[4] = '{8'h13, 8'h0E, 8'h06, 8'h00};
  int failures = 0;
  int num_checks = 0;
  int tick = 0;
  int seed;
  int src_cnt = 0;
  int snk_cnt = 0;
  logic [7:0] settle = 8'h00;
  wire pump_src = (src_cnt > snk_cnt);
  wire [17:0] act = {REFERENCE_OUTPUT, pump_src, OUTPUT_A, CHARGE_PUMP_OE, CP_CURRENT_PCT, BIAS_CURRENT_ON,
    OUTPUT_B_OE, OUTPUT_B_O,
    REF_RESISTOR_ON, REF_PULSE_OUT_N, FB_PULSE_OUT_N, LOCK_DETECT_OUTPUT};

  pcsc_top dut_u (
    .CLK(CLK), .RST_N(RST_N), .SER_CLK(SER_CLK), .SER_DATA(SER_DATA),
    .SERIAL_LATCH_STROBE_N(SERIAL_LATCH_STROBE_N), .REFERENCE_INPUT(REFERENCE_INPUT),
    .VCO_INPUT(VCO_INPUT), .REFERENCE_OUTPUT(REFERENCE_OUTPUT), .CHARGE_PUMP_OUTPUT(CHARGE_PUMP_OUTPUT),
    .CHARGE_PUMP_OE(CHARGE_PUMP_OE), .CP_CURRENT_PCT(CP_CURRENT_PCT), .REF_PULSE_OUT_N(REF_PULSE_OUT_N),
    .FB_PULSE_OUT_N(FB_PULSE_OUT_N), .LOCK_DETECT_OUTPUT(LOCK_DETECT_OUTPUT), .OUTPUT_A(OUTPUT_A),
    .OUTPUT_B_O(OUTPUT_B_O), .OUTPUT_B_OE(OUTPUT_B_OE), .BIAS_CURRENT_ON(BIAS_CURRENT_ON),
    .REF_RESISTOR_ON(REF_RESISTOR_ON)
  );

  pcsc_host host_u (.clk(CLK), .sck(SER_CLK), .sdi(SER_DATA), .strobe_n(SERIAL_LATCH_STROBE_N));

  // 125 MHz core clock
  always #4 CLK = ~CLK;

  // Print counts and verdict, then stop
  task automatic report_and_stop();
    $display("Checks %0d, mismatches %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // Expected snapshot as {mask, value} for a config byte
  function automatic logic [35:0] expv(input logic [7:0] cf, input logic port, input logic rm0);
    logic hold;
    logic [6:0] pct;
    logic [17:0] m;
    hold = cf[4];
    pct = (cf[1] && !port) ? 7'h19 * (cf[3:2] + 7'h01) : 7'h46 + 7'h0A * cf[3:2];
    m = {rm0, cf[6] & ~hold, port, hold | ~cf[6], 7'h7F, 4'hF, {2{hold | cf[6]}}, hold | ~cf[5]};
    return {m, 1'b0, ~cf[7], cf[1], 1'b0, pct, ~hold, ~cf[0], 1'b0, ~(hold & rm0), 2'b11, hold & cf[5]};
  endfunction

  // Pump direction tally once a new setting has settled; reference runs faster than feedback
  always @(posedge CLK) begin
    if (!SERIAL_LATCH_STROBE_N) settle <= 8'h00;
    else if (settle != 8'hFF) settle <= settle + 8'h01;
    if (settle < 8'h0C) begin
      src_cnt <= 0;
      snk_cnt <= 0;
    end else if (CHARGE_PUMP_OE === 1'b1) begin
      if (CHARGE_PUMP_OUTPUT === 1'b1) src_cnt <= src_cnt + 1;
      else snk_cnt <= snk_cnt + 1;
    end
  end

  // Note an expectation and ask the watcher to sample
  task automatic chk(input logic [7:0] cf, input logic port, input logic rm0);
    notes.push_back(expv(cf, port, rm0));
    sample <= 1'b1;
    @(posedge CLK);
    sample <= 1'b0;
    @(posedge CLK);
  endtask

  // Reference and VCO edges, plus the hang limit
  always @(posedge CLK) begin
    tick <= tick + 1;
    REFERENCE_INPUT <= tick[1];
    VCO_INPUT <= (tick % 6) < 3;
    if (tick == 30000) begin
      failures++;
      report_and_stop();
    end
  end

  // Compare each snapshot with the oldest note
  always @(posedge CLK) begin
    if (sample) begin
      nt = notes.pop_front();
      num_checks++;
      if (((act ^ nt[17:0]) & nt[35:18]) !== 18'h00000) begin
        failures++;
        $display("BAD %0t outputs %h expected %h mask %h", $time, act, nt[17:0], nt[35:18]);
      end
    end
  end

  // Main sequence
  initial begin
    seed = $urandom(32'h0B39);
    repeat (20) @(posedge CLK);
    RST_N <= 1'b1;
    @(posedge CLK);
    chk(8'h00, 1'b0, 1'b0);
    host_u.send(5'h10, 24'h000001, 1'b0);
    chk(8'h00, 1'b0, 1'b1);
    for (int k = 0; k < 16; k++) begin
      c = (8'($urandom) & 8'hF1) | {4'h0, k[2:0], 1'b0};
      host_u.send(5'h08, {16'h0000, c}, 1'b0);
      chk(c, 1'b0, 1'b1);
    end
    host_u.send(5'h18, 24'h400041, 1'b0);
    chk(c, 1'b1, 1'b1);
    foreach (pm[i]) begin
      host_u.send(5'h08, {16'h0000, pm[i]}, 1'b0);
      chk(pm[i], 1'b1, 1'b1);
    end
    host_u.send(5'h0C, 24'h000FFF, 1'b0);
    chk(8'h00, 1'b1, 1'b1);
    repeat (3) host_u.send(5'h05, 24'h00001F, 1'b1);
    chk(8'h00, 1'b0, 1'b0);
    host_u.send(5'h08, 24'h000010, 1'b0);
    chk(8'h10, 1'b0, 1'b0);
    report_and_stop();
  end
endmodule

// >>> verilog/pcsc_serial.sv
`timescale 1ns/1ps
`include "pcsc_consts.svh"
// Three-wire serial receiver on synchronised pins
module pcsc_serial import pcsc_pkg::*; (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic sck,
  input wire logic sdi,
  input wire logic strobe_n,
  output logic done,
  output pcsc_frame_t frame,
  output logic init_done,
  output logic shift_msb
);
  logic sck_d;
  logic strobe_d;
  logic [23:0] shreg;
  logic [4:0] count;
  logic init_wait;
  logic [7:0] hold_cnt;
  logic [1:0] groups;

  assign shift_msb = shreg[23];

  // Edge memory
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sck_d <= 1'b1;
      strobe_d <= 1'b1;
    end else begin
      sck_d <= sck;
      strobe_d <= strobe_n;
    end
  end

  // MSB first shift while strobe is low, frame on strobe rise
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      shreg <= '0;
      count <= '0;
      done <= 1'b0;
      frame <= '0;
    end else begin
      done <= 1'b0;
      if (!strobe_n && sck && !sck_d) begin
        shreg <= {shreg[22:0], sdi};
        if (count != 5'h1F)
          count <= count + 5'h01;
      end
      if (strobe_n && !strobe_d) begin
        done <= 1'b1;
        frame.count <= count;
        frame.data <= shreg;
        count <= '0;
      end
    end
  end

  // Five-bit groups with clock held high after strobe rise
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      init_wait <= 1'b0;
      hold_cnt <= '0;
      groups <= '0;
      init_done <= 1'b0;
    end else begin
      init_done <= 1'b0;
      if (strobe_n && !strobe_d) begin
        init_wait <= (count == `PCSC_LEN_INIT) && sck;
        hold_cnt <= '0;
        if (count != `PCSC_LEN_INIT)
          groups <= '0;
      end else if (init_wait) begin
        if (!sck || !strobe_n) begin
          init_wait <= 1'b0;
          groups <= '0;
        end else if (hold_cnt == 8'(`PCSC_INIT_HOLD_CYC - 1)) begin
          init_wait <= 1'b0;
          if (groups == `PCSC_INIT_GROUPS - 2'h1) begin
            groups <= '0;
            init_done <= 1'b1;
          end else begin
            groups <= groups + 2'h1;
          end
        end else begin
          hold_cnt <= hold_cnt + 8'h01;
        end
      end
    end
  end
endmodule

// >>> verilog/pcsc_sync.sv
`timescale 1ns/1ps
// Two-stage synchroniser for pin inputs
module pcsc_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout
);
  logic [WIDTH-1:0] stage1;

  // Second stage alone reads the first
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      stage1 <= '0;
      dout <= '0;
    end else begin
      stage1 <= din;
      dout <= stage1;
    end
  end
endmodule

// >>> verilog/pcsc_top.sv
`timescale 1ns/1ps
`include "pcsc_consts.svh"
// Overview of operation
// - Eight-bit transfer loads configuration register at strobe end, nothing else
// - Polarity bit inverts charge pump and swaps the two pulse outputs
// - Select bit: charge pump active, pair high; clear: pair active, pump floats
// - Lock detect driven only with its enable bit, else static low
// - Hold bit: pump floats, pair high, R and feedback counters stop, bias off
// - In hold, lock detect equals its enable bit
// - All registers keep contents through hold
// - Reference mode kept in hold; in hold, static low mode inhibits reference input
// - Leaving hold: counters and bias back first, detector pulses still blocked
// - First feedback pulse jam-loads R counter, resets detectors, reopens pulses
// - Port bit low, no port: 70, 80, 90, 100 percent
// - Port bit high, no port: 25, 50, 75, 100 percent
// - Port mode: output one follows port bit, 10 percent steps
// - Port bit and open-drain bit unaffected by hold
// - Open-drain output floats when its bit set, low when clear
// - Output one is serial data out after reset
// - A load copies low 13 bits of R first buffer to second
// - Lock detect is AND of the two detector pulses before forcing, not of the pulse output pins
module pcsc_top import pcsc_pkg::*; #(
  parameter int R_WIDTH = 13,
  parameter int FB_WIDTH = 18
) (
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic SER_CLK,
  input wire logic SER_DATA,
  input wire logic SERIAL_LATCH_STROBE_N,
  input wire logic REFERENCE_INPUT,
  input wire logic VCO_INPUT,
  output logic REFERENCE_OUTPUT,
  output logic CHARGE_PUMP_OUTPUT,
  output logic CHARGE_PUMP_OE,
  output logic [6:0] CP_CURRENT_PCT,
  output logic REF_PULSE_OUT_N,
  output logic FB_PULSE_OUT_N,
  output logic LOCK_DETECT_OUTPUT,
  output logic OUTPUT_A,
  output logic OUTPUT_B_O,
  output logic OUTPUT_B_OE,
  output logic BIAS_CURRENT_ON,
  output logic REF_RESISTOR_ON
);
  logic sck;
  logic sdi;
  logic strobe_on;
  logic ref_in;
  logic vco_in;
  logic ref_d;
  logic vco_d;
  logic done;
  pcsc_frame_t frame;
  logic init_done;
  logic shift_msb;
  pcsc_cfg_t cfg;
  logic [2:0] ref_mode;
  logic [R_WIDTH-1:0] r_first;
  logic [R_WIDTH-1:0] r_second;
  logic [23:0] a_reg;
  pcsc_state_t state;
  logic [R_WIDTH-1:0] rcnt;
  logic [FB_WIDTH-1:0] fcnt;
  logic reference_pulse;
  logic feedback_pulse;
  logic up;
  logic dn;
  logic [3:0] refdiv;
  logic counting;
  logic ref_gate;
  logic port_mode;
  logic det_r_n;
  logic det_v_n;
  logic next_ref_out;

  // Charge-pump current in percent of maximum
  function automatic logic [6:0] step_pct(input logic [1:0] sel, input logic coarse);
    logic [6:0] pct;
    pct = 7'h64;
    if (coarse)
      pct = 7'(8'h19 * ({6'h00, sel} + 8'h01));
    else
      pct = 7'(8'h46 + 8'h0A * {6'h00, sel});
    return pct;
  endfunction

  // Divider reload value never below one
  function automatic logic [FB_WIDTH-1:0] at_least_one(input logic [FB_WIDTH-1:0] v);
    return (v == '0) ? {{(FB_WIDTH-1){1'b0}}, 1'b1} : v;
  endfunction

  pcsc_sync #(.WIDTH(5)) u_sync (
    .clk(CLK),
    .rst_n(RST_N),
    .din({SER_CLK, SER_DATA, !SERIAL_LATCH_STROBE_N, REFERENCE_INPUT, VCO_INPUT}), // Strobe inverted: flushes to idle
    .dout({sck, sdi, strobe_on, ref_in, vco_in})
  );

  pcsc_serial u_serial (
    .clk(CLK),
    .rst_n(RST_N),
    .sck(sck),
    .sdi(sdi),
    .strobe_n(!strobe_on),
    .done(done),
    .frame(frame),
    .init_done(init_done),
    .shift_msb(shift_msb)
  );

  // Register loads by transfer length; other lengths ignored
  always_ff @(posedge CLK) begin
    if (!RST_N || init_done) begin
      cfg <= pcsc_cfg_t'(`PCSC_CFG_RESET);
      ref_mode <= `PCSC_R_MODE_RESET;
      r_first <= R_WIDTH'(`PCSC_R_DIV_RESET);
      r_second <= R_WIDTH'(`PCSC_R_DIV_RESET);
      a_reg <= `PCSC_A_RESET;
    end else if (done) begin
      case (frame.count)
        `PCSC_LEN_CFG: begin
          cfg <= pcsc_cfg_t'(frame.data[7:0]);
        end
        `PCSC_LEN_R: begin
          ref_mode <= frame.data[`PCSC_R_MODE_HI:`PCSC_R_MODE_LO];
          r_first <= frame.data[R_WIDTH-1:0];
        end
        `PCSC_LEN_A: begin
          a_reg <= frame.data;
          r_second <= r_first;
        end
        default: begin
          a_reg <= a_reg;
        end
      endcase
    end
  end

  // Hold entry and two-step recovery
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      state <= PCSC_RUN;
    end else begin
      case (state)
        PCSC_RUN: begin
          if (cfg.low_power_hold)
            state <= PCSC_HOLD;
        end
        PCSC_HOLD: begin
          if (!cfg.low_power_hold)
            state <= PCSC_ARM;
        end
        PCSC_ARM: begin
          if (cfg.low_power_hold)
            state <= PCSC_HOLD;
          else if (feedback_pulse)
            state <= PCSC_RUN;
        end
        default: begin
          state <= PCSC_HOLD;
        end
      endcase
    end
  end

  assign counting = (state != PCSC_HOLD);
  assign ref_gate = !((state == PCSC_HOLD) && (ref_mode == `PCSC_REF_LOW));
  assign port_mode = (a_reg[`PCSC_A_FUNC_HI:`PCSC_A_FUNC_LO] == `PCSC_A_PORT_CODE);

  // Input edge memory
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      ref_d <= 1'b0;
      vco_d <= 1'b0;
    end else begin
      ref_d <= ref_in && ref_gate;
      vco_d <= vco_in;
    end
  end

  // R counter divides reference edges
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      rcnt <= R_WIDTH'(`PCSC_R_DIV_RESET);
      reference_pulse <= 1'b0;
    end else begin
      reference_pulse <= 1'b0;
      if (state == PCSC_ARM && feedback_pulse) begin
        rcnt <= r_second;
      end else if (counting && ref_in && ref_gate && !ref_d) begin
        if (rcnt <= R_WIDTH'(1)) begin
          rcnt <= R_WIDTH'(at_least_one(FB_WIDTH'(r_second)));
          reference_pulse <= 1'b1;
        end else begin
          rcnt <= rcnt - R_WIDTH'(1);
        end
      end
    end
  end

  // Feedback counter divides by N times 64 plus A
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      fcnt <= FB_WIDTH'(1);
      feedback_pulse <= 1'b0;
    end else begin
      feedback_pulse <= 1'b0;
      if (counting && vco_in && !vco_d) begin
        if (fcnt <= FB_WIDTH'(1)) begin
          fcnt <= at_least_one(a_reg[`PCSC_A_TOTAL_HI:0]);
          feedback_pulse <= 1'b1;
        end else begin
          fcnt <= fcnt - FB_WIDTH'(1);
        end
      end
    end
  end

  // Phase/frequency detector state, blocked until recovery ends
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      up <= 1'b0;
      dn <= 1'b0;
    end else if (state != PCSC_RUN) begin
      up <= 1'b0;
      dn <= 1'b0;
    end else if (up && dn) begin
      up <= 1'b0;
      dn <= 1'b0;
    end else begin
      up <= up || reference_pulse;
      dn <= dn || feedback_pulse;
    end
  end

  // Pulse pair before forcing, swapped by polarity
  assign det_r_n = cfg.detector_polarity ? !dn : !up;
  assign det_v_n = cfg.detector_polarity ? !up : !dn;

  // Reference output divider
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      refdiv <= '0;
    end else if (ref_in && ref_gate && !ref_d) begin
      refdiv <= refdiv + 4'h1;
    end
  end

  // Reference output by mode
  always_comb begin
    next_ref_out = 1'b0;
    if (ref_mode == `PCSC_REF_PASS)
      next_ref_out = ref_in && ref_gate;
    else if (ref_mode >= `PCSC_REF_DIV2)
      next_ref_out = refdiv[2'(ref_mode - `PCSC_REF_DIV2)];
  end

  // Registered pin drivers
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      REFERENCE_OUTPUT <= 1'b0;
      CHARGE_PUMP_OUTPUT <= 1'b0;
      CHARGE_PUMP_OE <= 1'b0;
      CP_CURRENT_PCT <= 7'h46;
      REF_PULSE_OUT_N <= 1'b1;
      FB_PULSE_OUT_N <= 1'b1;
      LOCK_DETECT_OUTPUT <= 1'b0;
      OUTPUT_A <= 1'b0;
      OUTPUT_B_O <= 1'b0;
      OUTPUT_B_OE <= 1'b1;
      BIAS_CURRENT_ON <= 1'b1;
      REF_RESISTOR_ON <= 1'b1;
    end else begin
      REFERENCE_OUTPUT <= next_ref_out;
      // Charge pump: active only when selected and not holding
      if (cfg.detector_select && state != PCSC_HOLD) begin
        CHARGE_PUMP_OE <= up || dn;
        CHARGE_PUMP_OUTPUT <= cfg.detector_polarity ? dn : up;
      end else begin
        CHARGE_PUMP_OE <= 1'b0;
        CHARGE_PUMP_OUTPUT <= 1'b0;
      end
      if (port_mode)
        CP_CURRENT_PCT <= step_pct({cfg.current_step_high, cfg.current_step_low}, 1'b0);
      else
        CP_CURRENT_PCT <= step_pct({cfg.current_step_high, cfg.current_step_low}, cfg.port_bit);
      // Pair forced high when select bit set or holding
      if (cfg.detector_select || state == PCSC_HOLD) begin
        REF_PULSE_OUT_N <= 1'b1;
        FB_PULSE_OUT_N <= 1'b1;
      end else begin
        REF_PULSE_OUT_N <= det_r_n;
        FB_PULSE_OUT_N <= det_v_n;
      end
      // Lock detect
      if (state == PCSC_HOLD)
        LOCK_DETECT_OUTPUT <= cfg.lock_detect_enable;
      else
        LOCK_DETECT_OUTPUT <= cfg.lock_detect_enable && det_r_n && det_v_n;
      OUTPUT_A <= port_mode ? cfg.port_bit : shift_msb;
      OUTPUT_B_O <= 1'b0;
      OUTPUT_B_OE <= !cfg.outb_bit;
      BIAS_CURRENT_ON <= (state != PCSC_HOLD);
      REF_RESISTOR_ON <= ref_gate;
    end
  end
endmodule
